//--- logic/output_function_selector.sv
// Purpose: Routes internal machine signals onto output pins by function code
// Assumes: Classic Wishbone slave, one clock, synchronous inputs
// Notes:   Duty gating uses a PWM frame of sixteen ticks
`timescale 1ns/1ps
`include "output_function_selector_params.svh"

module output_function_selector #(
  parameter int unsigned NUM_PINS  = 16,
  parameter int unsigned TICK_CYC  = `OFS_DUTY_TICK_CYC
) (
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  input  wire logic                 wb_cyc_i,
  input  wire logic                 wb_stb_i,
  input  wire logic                 wb_we_i,
  input  wire logic [7:0]           wb_adr_i,
  input  wire logic [3:0]           wb_sel_i,
  input  wire logic [31:0]          wb_dat_i,
  output logic      [31:0]          wb_dat_o,
  output logic                      wb_ack_o,
  input  wire logic                 sol_backtack_i,
  input  wire logic                 sol_foot_lift_i,
  input  wire logic                 sol_trim_i,
  input  wire logic                 sol_wiper_i,
  input  wire logic                 sol_tension_i,
  input  wire logic                 sol_left_i,
  input  wire logic                 sol_right_i,
  input  wire logic                 sol_aux_i,
  input  wire logic                 led_left_i,
  input  wire logic                 led_right_i,
  input  wire logic                 needle_up_i,
  input  wire logic                 needle_down_i,
  input  wire logic                 motor_run_i,
  input  wire logic                 target_speed_i,
  input  wire logic                 trimming_i,
  input  wire logic                 end_backtack_i,
  input  wire logic                 error_halt_i,
  input  wire logic                 roller_switch_i,
  input  wire logic                 hemming_i,
  input  wire logic                 pedal_fwd_i,
  output logic      [NUM_PINS-1:0]  pin_o,
  output logic                      irq_o
);

  localparam int unsigned NF = output_function_selector_pkg::NUM_FN;

  output_function_selector_pkg::sel_code_t sel_r [NUM_PINS];
  output_function_selector_pkg::sel_code_t sel_nxt [NUM_PINS];
  logic [4:0]             duty_r, duty_nxt;
  logic [`OFS_IRQ_W-1:0]  stat_r, stat_nxt, mask_r, mask_nxt;
  logic [NUM_PINS-1:0]    pin_nxt;
  logic                   ack_nxt, irq_nxt, estop_d_r;
  logic [31:0]            dat_nxt;
  logic [15:0]            tick_r, tick_nxt;
  logic [3:0]             frame_r, frame_nxt;
  logic                   pwm_on;
  logic [NF-1:0]          fn_sig;
  logic                   roller_lift;
  logic                   req, wr, bad_wr;
  logic [5:0]             word;

  // Code is defined: 0..19, 100..119, 200, 201
  function automatic logic code_valid(input logic [7:0] c);
    code_valid = (c < 8'(NF))
      || (c >= output_function_selector_pkg::FN_INV_BASE
          && c <= output_function_selector_pkg::FN_INV_LAST)
      || c == output_function_selector_pkg::FN_FIXED_LOW
      || c == output_function_selector_pkg::FN_FIXED_HIGH;
  endfunction : code_valid

  // Level for one pin given its code
  function automatic logic route(input logic [7:0] c, input logic [NF-1:0] s,
                                 input logic pwm);
    logic [7:0] base;
    logic       v;
    base = (c >= output_function_selector_pkg::FN_INV_BASE)
         ? 8'(c - output_function_selector_pkg::FN_INV_BASE) : c;
    v = 1'b0;
    if (base < 8'(NF)) begin
      v = s[base[4:0]];
      if (base <= output_function_selector_pkg::FN_LAST_MOD) begin
        v = v & pwm;
      end
    end
    if (c == output_function_selector_pkg::FN_FIXED_HIGH) begin
      route = 1'b1;
    end else if (!code_valid(c) || c == output_function_selector_pkg::FN_FIXED_LOW) begin
      route = 1'b0;
    end else if (c >= output_function_selector_pkg::FN_INV_BASE) begin
      route = ~v;
    end else begin
      route = v;
    end
  endfunction : route

  assign roller_lift = sol_foot_lift_i | sol_backtack_i | roller_switch_i;

  assign fn_sig = {pedal_fwd_i, hemming_i, roller_lift, error_halt_i, end_backtack_i,
                   trimming_i, target_speed_i, motor_run_i, needle_down_i, needle_up_i,
                   led_right_i, led_left_i, sol_aux_i, sol_right_i, sol_left_i,
                   sol_tension_i, sol_wiper_i, sol_trim_i, sol_foot_lift_i, sol_backtack_i};

  // Duty frame: gate is open for duty_on ticks of sixteen
  assign pwm_on = !duty_r[`OFS_DUTY_EN_BIT]
               || (frame_r < duty_r[`OFS_DUTY_ON_W-1:`OFS_DUTY_ON_LSB]);

  always_comb begin
    tick_nxt  = tick_r + 16'h0001;
    frame_nxt = frame_r;
    if (tick_r >= 16'(TICK_CYC - 1)) begin
      tick_nxt  = 16'h0000;
      frame_nxt = frame_r + 4'h1;
    end
  end

  assign req    = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr     = req & wb_we_i;
  assign word   = wb_adr_i[7:2];
  assign bad_wr = wr && wb_sel_i[0] && word < 6'(NUM_PINS) && !code_valid(wb_dat_i[7:0]);

  // Register file, read mux and interrupt status
  always_comb begin
    for (int k = 0; k < NUM_PINS; k++) begin
      sel_nxt[k] = sel_r[k];
    end
    duty_nxt = duty_r;
    mask_nxt = mask_r;
    stat_nxt = stat_r;
    dat_nxt  = 32'h0000_0000;
    ack_nxt  = req;
    if (wr && wb_sel_i[0]) begin
      if (word < 6'(NUM_PINS)) begin
        sel_nxt[word[3:0]] = wb_dat_i[7:0];
      end else if ({word, 2'b00} == `OFS_DUTY_CTRL) begin
        duty_nxt = wb_dat_i[4:0];
      end else if ({word, 2'b00} == `OFS_IRQ_MASK) begin
        mask_nxt = wb_dat_i[`OFS_IRQ_W-1:0];
      end else if ({word, 2'b00} == `OFS_IRQ_STATUS) begin
        stat_nxt = stat_r & ~wb_dat_i[`OFS_IRQ_W-1:0];
      end
    end
    // Set wins over a same-cycle clear
    if (error_halt_i && !estop_d_r) begin
      stat_nxt[`OFS_IRQ_ESTOP_BIT] = 1'b1;
    end
    if (bad_wr) begin
      stat_nxt[`OFS_IRQ_BADSEL_BIT] = 1'b1;
    end
    if (req && !wb_we_i) begin
      if (word < 6'(NUM_PINS)) begin
        dat_nxt = {24'h000000, sel_r[word[3:0]]};
      end else if ({word, 2'b00} == `OFS_DUTY_CTRL) begin
        dat_nxt = {27'h0, duty_r};
      end else if ({word, 2'b00} == `OFS_IRQ_STATUS) begin
        dat_nxt = {30'h0, stat_r};
      end else if ({word, 2'b00} == `OFS_IRQ_MASK) begin
        dat_nxt = {30'h0, mask_r};
      end else if ({word, 2'b00} == `OFS_PIN_STATE) begin
        dat_nxt = {{(32-NUM_PINS){1'b0}}, pin_o};
      end
    end
    irq_nxt = |(stat_nxt & mask_nxt);
  end

  // Each pin routes independently, so shared codes give equal levels
  generate
    for (genvar p = 0; p < NUM_PINS; p++) begin : g_pin
      assign pin_nxt[p] = route(sel_r[p], fn_sig, pwm_on);
    end
  endgenerate

  // Selector bank; reset maps pin k to function k
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int k = 0; k < NUM_PINS; k++) begin
        sel_r[k] <= 8'(k);
      end
    end else begin
      for (int k = 0; k < NUM_PINS; k++) begin
        sel_r[k] <= sel_nxt[k];
      end
    end
  end

  // Duty control, mask and sticky status
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      duty_r    <= `OFS_DUTY_RESET;
      mask_r    <= '0;
      stat_r    <= '0;
      estop_d_r <= 1'b0;
    end else begin
      duty_r    <= duty_nxt;
      mask_r    <= mask_nxt;
      stat_r    <= stat_nxt;
      estop_d_r <= error_halt_i;
    end
  end

  // Bus answer and interrupt line
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o  <= 32'h0000_0000;
      wb_ack_o  <= 1'b0;
      irq_o     <= 1'b0;
    end else begin
      wb_dat_o  <= dat_nxt;
      wb_ack_o  <= ack_nxt;
      irq_o     <= irq_nxt;
    end
  end

  // Pins, low in reset so no load fires early
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_o     <= '0;
    end else begin
      pin_o     <= pin_nxt;
    end
  end

  // Duty timebase
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tick_r    <= 16'h0000;
      frame_r   <= 4'h0;
    end else begin
      tick_r    <= tick_nxt;
      frame_r   <= frame_nxt;
    end
  end

  chk_motor_run_route: assert property (@(posedge clk_i) disable iff (rst_i)
    sel_r[0] == 8'h0c |=> pin_o[0] == ($past(motor_run_i) & $past(pwm_on)))
    else $error("motor running code not routed");
  chk_target_speed_route: assert property (@(posedge clk_i) disable iff (rst_i)
    sel_r[1] == 8'h0d |=> pin_o[1] == ($past(target_speed_i) & $past(pwm_on)))
    else $error("target speed code not routed");
  chk_backtack_plain_level: assert property (@(posedge clk_i) disable iff (rst_i)
    sel_r[2] == 8'h0f |=> pin_o[2] == $past(end_backtack_i))
    else $error("end back tack not a plain level");
  chk_estop_route: assert property (@(posedge clk_i) disable iff (rst_i)
    sel_r[3] == 8'h10 && error_halt_i |=> pin_o[3])
    else $error("error stop not shown");
  chk_pedal_inverse: assert property (@(posedge clk_i) disable iff (rst_i)
    sel_r[4] == 8'h77 |=> pin_o[4] == !$past(pedal_fwd_i))
    else $error("pedal inverse wrong");
  chk_roller_lift_combine: assert property (@(posedge clk_i) disable iff (rst_i)
    sel_r[5] == 8'h11 |=> pin_o[5] == $past(roller_lift))
    else $error("roller lift not routed");
  chk_roller_lift_terms: assert property (@(posedge clk_i) disable iff (rst_i)
    sel_r[6] == 8'h75 && (sol_foot_lift_i || sol_backtack_i || roller_switch_i) |=> !pin_o[6])
    else $error("roller lift complement high while a term is set");
  chk_shared_code_equal: assert property (@(posedge clk_i) disable iff (rst_i)
    sel_r[0] == sel_r[1] |=> pin_o[0] == pin_o[1])
    else $error("pins sharing a code differ");
  chk_undefined_code_low: assert property (@(posedge clk_i) disable iff (rst_i)
    !code_valid(sel_r[7]) |=> !pin_o[7])
    else $error("undefined code drove a pin");
  chk_inverse_pairing: assert property (@(posedge clk_i) disable iff (rst_i)
    sel_r[8] < 8'h14 && sel_r[9] == 8'(sel_r[8] + 8'h64) |=> pin_o[8] != pin_o[9])
    else $error("inverse code not complement");
  chk_ack_one_cycle: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held too long");

  // Routing, status and bus checks beyond the per-rule ones
  chk_fixed_high_level: assert property (@(posedge clk_i) disable iff (rst_i)
    sel_r[12] == 8'hc9 |=> pin_o[12])
    else $error("fixed high code not high");
  chk_fixed_low_level: assert property (@(posedge clk_i) disable iff (rst_i)
    sel_r[12] == 8'hc8 |=> !pin_o[12])
    else $error("fixed low code not low");
  chk_trim_unmodulated: assert property (@(posedge clk_i) disable iff (rst_i)
    sel_r[10] == 8'h0e |=> pin_o[10] == $past(trimming_i))
    else $error("trimming code gated");
  chk_hemming_inverse: assert property (@(posedge clk_i) disable iff (rst_i)
    sel_r[11] == 8'h76 |=> pin_o[11] == !$past(hemming_i))
    else $error("hemming inverse wrong");
  chk_estop_inverse: assert property (@(posedge clk_i) disable iff (rst_i)
    sel_r[13] == 8'h74 && error_halt_i |=> !pin_o[13])
    else $error("error stop inverse high during halt");
  chk_roller_lift_inverse: assert property (@(posedge clk_i) disable iff (rst_i)
    sel_r[14] == 8'h75 |=> pin_o[14] == !$past(roller_lift))
    else $error("roller lift complement wrong");
  chk_pedal_plain: assert property (@(posedge clk_i) disable iff (rst_i)
    sel_r[15] == 8'h13 |=> pin_o[15] == $past(pedal_fwd_i))
    else $error("pedal indication wrong");
  chk_undefined_last_pin: assert property (@(posedge clk_i) disable iff (rst_i)
    !code_valid(sel_r[15]) |=> !pin_o[15])
    else $error("undefined code drove last pin");
  chk_shared_code_far: assert property (@(posedge clk_i) disable iff (rst_i)
    sel_r[0] == sel_r[15] |=> pin_o[0] == pin_o[15])
    else $error("far pins sharing a code differ");
  chk_gate_shut_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    duty_r[4] && duty_r[3:0] == 4'h0 |-> !pwm_on)
    else $error("gate open with zero on-ticks");
  chk_gate_open_off: assert property (@(posedge clk_i) disable iff (rst_i)
    !duty_r[4] |-> pwm_on)
    else $error("gate shut with duty disabled");
  chk_estop_status_set: assert property (@(posedge clk_i) disable iff (rst_i)
    error_halt_i && !estop_d_r |=> stat_r[0])
    else $error("error stop status not set");
  chk_badsel_status_set: assert property (@(posedge clk_i) disable iff (rst_i)
    bad_wr |=> stat_r[1])
    else $error("undefined code write not flagged");
  chk_irq_level: assert property (@(posedge clk_i) disable iff (rst_i)
    irq_o == (|(stat_r & mask_r)))
    else $error("interrupt level wrong");
  chk_ack_follows_req: assert property (@(posedge clk_i) disable iff (rst_i)
    req |=> wb_ack_o)
    else $error("request not acknowledged");
  chk_dat_idle_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    !wb_ack_o |-> wb_dat_o == 32'h0000_0000)
    else $error("read data not zero when idle");
  chk_frame_advance: assert property (@(posedge clk_i) disable iff (rst_i)
    tick_r == 16'(TICK_CYC - 1) |=> frame_r == 4'($past(frame_r) + 4'h1))
    else $error("duty frame did not advance");

  cov_shared_pins: cover property (@(posedge clk_i) disable iff (rst_i)
    sel_r[0] == sel_r[1] && pin_o[0] && pin_o[1]);
  cov_estop_irq: cover property (@(posedge clk_i) disable iff (rst_i)
    error_halt_i ##2 irq_o);
  cov_duty_gated: cover property (@(posedge clk_i) disable iff (rst_i)
    motor_run_i && !pwm_on && sel_r[0] == 8'h0c);
  cov_fixed_high: cover property (@(posedge clk_i) disable iff (rst_i)
    sel_r[0] == 8'hc9 ##1 pin_o[0]);
  cov_badsel_irq: cover property (@(posedge clk_i) disable iff (rst_i)
    bad_wr ##1 irq_o);

endmodule : output_function_selector

//--- logic/output_function_selector_params.svh
// Purpose: Constants for the output function selector
// Assumes: Byte addresses on a 32-bit classic Wishbone bus
// Notes:   Selector of pin k sits at SEL_BASE + 4*k
`ifndef OUTPUT_FUNCTION_SELECTOR_PARAMS_SVH
`define OUTPUT_FUNCTION_SELECTOR_PARAMS_SVH

`define OFS_SEL_BASE      8'h00
`define OFS_DUTY_CTRL     8'h40
`define OFS_IRQ_STATUS    8'h44
`define OFS_IRQ_MASK      8'h48
`define OFS_PIN_STATE     8'h4c

`define OFS_DUTY_ON_LSB   0
`define OFS_DUTY_ON_W     4
`define OFS_DUTY_EN_BIT   4
`define OFS_DUTY_RESET    5'h18

`define OFS_IRQ_ESTOP_BIT 0
`define OFS_IRQ_BADSEL_BIT 1
`define OFS_IRQ_W         2

`define OFS_CLK_NS        10
`define OFS_DUTY_TICK_NS  10000
`define OFS_DUTY_TICK_CYC (`OFS_DUTY_TICK_NS / `OFS_CLK_NS)

`endif

//--- logic/output_function_selector_pkg.sv
// Purpose: Types for the output function selector
// Assumes: Selector codes fit in eight bits
// Notes:   Codes 100..119 invert codes 0..19
package output_function_selector_pkg;

  typedef logic [7:0] sel_code_t;

  // Last code that passes through the duty gate; kept out of the enum to avoid a duplicate value
  localparam logic [7:0] FN_LAST_MOD = 8'h0d;

  typedef enum logic [7:0] {
    FN_MOTOR_RUN   = 8'h0c,
    FN_TARGET_SPD  = 8'h0d,
    FN_TRIMMING    = 8'h0e,
    FN_END_BACKTK  = 8'h0f,
    FN_ESTOP       = 8'h10,
    FN_ROLLER_LIFT = 8'h11,
    FN_HEMMING     = 8'h12,
    FN_PEDAL_FWD   = 8'h13,
    FN_INV_BASE    = 8'h64,
    FN_INV_LAST    = 8'h77,
    FN_FIXED_LOW   = 8'hc8,
    FN_FIXED_HIGH  = 8'hc9
  } fn_code_t;

  localparam int unsigned NUM_FN = 20;

endpackage : output_function_selector_pkg

//--- tb/output_function_selector_tb_top.sv
// Purpose: Self-checking bench for the output function selector
// Assumes: One-cycle registered ack, duty tick shortened to 4 cycles
// Notes:   Random codes include undefined ones and duplicates
`timescale 1ns/1ps

module output_function_selector_tb_top;
  logic        clk_i, rst_i, cyc, stb, we;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] dat, dat_o, q;
  logic        ack, irq_o;
  logic [19:0] fn_in;
  logic [15:0] pin_o, seen, exp_v;
  logic [7:0]  codes [16];
  int          seed, fails, n_tests;

  output_function_selector #(.NUM_PINS(16), .TICK_CYC(4)) DUT (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .sol_backtack_i(fn_in[0]), .sol_foot_lift_i(fn_in[1]), .sol_trim_i(fn_in[2]),
    .sol_wiper_i(fn_in[3]), .sol_tension_i(fn_in[4]), .sol_left_i(fn_in[5]),
    .sol_right_i(fn_in[6]), .sol_aux_i(fn_in[7]), .led_left_i(fn_in[8]),
    .led_right_i(fn_in[9]), .needle_up_i(fn_in[10]), .needle_down_i(fn_in[11]),
    .motor_run_i(fn_in[12]), .target_speed_i(fn_in[13]), .trimming_i(fn_in[14]),
    .end_backtack_i(fn_in[15]), .error_halt_i(fn_in[16]), .roller_switch_i(fn_in[17]),
    .hemming_i(fn_in[18]), .pedal_fwd_i(fn_in[19]), .pin_o(pin_o), .irq_o(irq_o));

  pin_load_model #(.N(16)) load (.clk_i(clk_i), .pins_i(pin_o), .seen_o(seen));

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  task automatic close_out;
    $display("Counts: %0d checks, %0d mismatches", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : close_out

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Called just after a rising edge; holds the request until ack is seen
  task automatic wb_xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d; sel <= 4'hf;
    @(posedge clk_i);
    while (ack !== 1'b1 && n < 20) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 20) chk(32'h0, 32'h1);
    q = dat_o;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    @(posedge clk_i);
  endtask : wb_xfer

  function automatic logic f_exp(input logic [7:0] c, input logic [19:0] s, input logic g);
    logic       b;
    logic [7:0] n;
    n = (c >= 8'h64 && c <= 8'h77) ? c - 8'h64 : c;
    if (c == 8'hc8) return 1'b0;
    if (c == 8'hc9) return 1'b1;
    if (n > 8'h13) return 1'b0;
    b = (n == 8'h11) ? (s[0] | s[1] | s[17]) : s[n[4:0]];
    if (n < 8'h0e) b = b & g;
    return (c >= 8'h64) ? ~b : b;
  endfunction : f_exp

  function automatic logic [7:0] pick(input int r);
    int k;
    k = (r & 32'h7fff) % 45;
    if (k < 20) return k[7:0];
    if (k < 40) return k[7:0] + 8'h50;
    case (k)
      40: return 8'hc8;
      41: return 8'hc9;
      42: return 8'h14;
      43: return 8'h63;
      default: return 8'hca;
    endcase
  endfunction : pick

  // Writes all selectors, lets pins and loads settle, checks both views
  task automatic apply_and_check(input logic g);
    for (int p = 0; p < 16; p++) wb_xfer(1'b1, 8'(4 * p), {24'h0, codes[p]});
    repeat (3) @(posedge clk_i);
    for (int p = 0; p < 16; p++) exp_v[p] = f_exp(codes[p], fn_in, g);
    chk({16'h0, seen}, {16'h0, exp_v});
    wb_xfer(1'b0, 8'h4c, 32'h0);
    chk(q, {16'h0, exp_v});
  endtask : apply_and_check

  initial begin
    #400000;
    fails++;
    close_out();
  end

  initial begin
    seed = 22473; fails = 0; n_tests = 0;
    rst_i = 1'b1; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 8'h0; sel = 4'h0; dat = 32'h0;
    fn_in = 20'h0;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wb_xfer(1'b0, 8'h14, 32'h0);
    chk(q, 32'h5);
    wb_xfer(1'b0, 8'h40, 32'h0);
    chk(q, 32'h18);
    wb_xfer(1'b1, 8'h80, 32'hff);
    wb_xfer(1'b0, 8'h80, 32'h0);
    chk(q, 32'h0);
    $display("Test reset and map done");
    // Duty off so every modulated code passes its source as is
    wb_xfer(1'b1, 8'h40, 32'h0);
    for (int it = 0; it < 40; it++) begin
      fn_in <= 20'($random(seed));
      for (int p = 0; p < 16; p++) codes[p] = pick($random(seed));
      if (it == 0) codes[3] = codes[0];
      if (it == 1) for (int p = 0; p < 16; p++) codes[p] = (p < 8) ? 8'(p + 12) : 8'(p + 104);
      apply_and_check(1'b1);
    end
    $display("Test random routing done");
    // Enabled duty with zero on-ticks keeps the gate shut
    wb_xfer(1'b1, 8'h40, 32'h10);
    fn_in <= 20'hfffff;
    for (int p = 0; p < 16; p++) codes[p] = (p < 8) ? 8'(p + 8) : 8'(p + 100);
    apply_and_check(1'b0);
    $display("Test duty gating done");
    wb_xfer(1'b1, 8'h40, 32'h0);
    wb_xfer(1'b1, 8'h48, 32'h1);
    fn_in[16] <= 1'b0;
    repeat (2) @(posedge clk_i);
    wb_xfer(1'b1, 8'h44, 32'h3);
    @(posedge clk_i);
    chk({31'h0, irq_o}, 32'h0);
    fn_in[16] <= 1'b1;
    repeat (3) @(posedge clk_i);
    chk({31'h0, irq_o}, 32'h1);
    wb_xfer(1'b0, 8'h44, 32'h0);
    chk(q & 32'h1, 32'h1);
    wb_xfer(1'b1, 8'h48, 32'h0);
    @(posedge clk_i);
    chk({31'h0, irq_o}, 32'h0);
    wb_xfer(1'b1, 8'h48, 32'h1);
    @(posedge clk_i);
    chk({31'h0, irq_o}, 32'h1);
    wb_xfer(1'b1, 8'h44, 32'h1);
    @(posedge clk_i);
    chk({31'h0, irq_o}, 32'h0);
    wb_xfer(1'b1, 8'h48, 32'h2);
    wb_xfer(1'b1, 8'h44, 32'h3);
    chk({31'h0, irq_o}, 32'h0);
    wb_xfer(1'b1, 8'h00, 32'hca);
    chk({31'h0, irq_o}, 32'h1);
    $display("Test interrupt done");
    close_out();
  end
endmodule : output_function_selector_tb_top

//--- tb/pin_load_model.sv
// Purpose: Loads on the output pins: solenoids, lamps, receivers
// Assumes: Loads settle within one clock
// Notes:   Shows what each load last latched, one cycle behind
`timescale 1ns/1ps

module pin_load_model #(
  parameter int unsigned N = 16
) (
  input  wire logic         clk_i,
  input  wire logic [N-1:0] pins_i,
  output logic      [N-1:0] seen_o
);
  always_ff @(posedge clk_i) begin
    seen_o <= pins_i;
  end
endmodule : pin_load_model
